// ===== hdl/rtc_core_pkg.sv
// constants, types and register map of the rtc timekeeping core
// What this block does
// R1: time and calendar fields kept in BCD
// R2: century bit toggles on year 99 to 00
// R3: day-of-week steps at midnight, sequential codes
// R4: host writes only valid time and dates
// R5: calendar writes take effect after 3 ms
// R6: answer only to slave address 1101000
// R7: eighth address bit selects read or write
// R8: SCL held low too long resets slave
// R9: timeout releases SDA, needs running oscillator
// R10: bus timeout lies between 25 and 35 ms
// R11: new transaction after loss restarts state machine
// R12: primary interrupt is active-low open-drain
// R13: secondary pin: square wave or alarm interrupt; core drives only the clock (square wave or raw), no alarm interrupt
// R14: status bit and pin cleared by reading status
// R15: config 0x07 puts raw 32 kHz on pin
// R16: trim corrects time in 0.477 ppm steps
// R17: host computes code as error over 0.477
// R18: host splits code into high and low bytes
// R19: new trim applies when low byte written
// R20: factory trim loaded into offset registers at reset
// R21: second tick divided from oscillator, trim-adjusted
package rtc_core_pkg;
    // ------------------------------------------------------------
    // bus addressing
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_INT_EN = 8'h01;
    localparam logic [7:0] REG_CLK_CFG = 8'h04;
    localparam logic [7:0] REG_CAL_BASE = 8'h06;
    localparam logic [7:0] REG_TRIM_UPPER = 8'h1D;
    localparam logic [7:0] REG_TRIM_LOWER = 8'h1E;
    localparam int CAL_FIELDS = 7;
    // calendar field indices
    localparam int CAL_SEC = 0;
    localparam int CAL_MIN = 1;
    localparam int CAL_HOUR = 2;
    localparam int CAL_DOW = 3;
    localparam int CAL_DATE = 4;
    localparam int CAL_MONTH = 5;
    localparam int CAL_YEAR = 6;
    localparam int CENTURY_BIT = 7;
    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam int STAT_SEC_BIT = 0;
    localparam int CFG_CLK_EN_BIT = 2;
    localparam logic [1:0] CFG_SEL_RAW = 2'h3;
    localparam logic [7:0] CLK_CFG_RST = 8'h00;
    localparam logic [7:0] INT_EN_RST = 8'h00;
    localparam logic [7:0] CAL_ONE = 8'h01;
    localparam logic [15:0] FACTORY_TRIM_DEF = 16'h0000;
    localparam logic [7:0] DOW_LAST = 8'h07;
    // ------------------------------------------------------------
    // timing, counted in oscillator ticks
    // ------------------------------------------------------------
    localparam int OSC_HZ = 32768;
    localparam int WIN_MS = 3;
    localparam int WIN_TICKS = (WIN_MS * OSC_HZ + 999) / 1000;
    localparam int TMO_MS = 30;
    localparam int TMO_TICKS = TMO_MS * OSC_HZ / 1000;
    localparam int TRIM_FRAC_BITS = 6;
    localparam logic [16:0] SEC_PERIOD = 17'h08000;
    localparam logic [16:0] SQ_HALF = 17'h04000;
    // ------------------------------------------------------------
    // register access carried from the serial slave
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// ===== hdl/rtc_i2c_slave.sv
// serial two-wire slave with scl-low timeout
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_slave
    import rtc_core_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    // timeout time base
    input wire logic osc_tick_i,
    // register side
    input wire logic [7:0] rdata_i,
    output logic [7:0] ptr_o,
    output reg_req_t req_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_ADDR = 7'h02, S_ACK_A = 7'h04, S_WR = 7'h08,
        S_ACK_W = 7'h10, S_RD = 7'h20, S_ACK_R = 7'h40
    } i2c_state_t;

    typedef struct packed {
        logic [1:0] scl_sy;   // two-flop synchroniser
        logic [1:0] sda_sy;
        logic scl_d;          // previous synchronised levels
        logic sda_d;
        i2c_state_t st;
        logic [3:0] bits;
        logic [7:0] shift;
        logic first;          // next written byte is the pointer
        logic rw;
        logic ack_ok;
        logic sda_oe;
        logic [9:0] tmo;
        logic [7:0] ptr;
        reg_req_t req;
    } slave_t;

    slave_t r;
    slave_t next_r;
    logic scl;
    logic sda;
    logic rise;
    logic fall;

    assign scl = r.scl_sy[1];
    assign sda = r.sda_sy[1];
    assign rise = scl & ~r.scl_d;
    assign fall = ~scl & r.scl_d;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.scl_sy = {r.scl_sy[0], scl_i};
        next_r.sda_sy = {r.sda_sy[0], sda_i};
        next_r.scl_d = scl;
        next_r.sda_d = sda;
        next_r.req.wr = 1'b0;
        next_r.req.rd = 1'b0;
        // count oscillator ticks while scl sits low
        if (scl) begin
            next_r.tmo = '0;
        end else if (osc_tick_i && r.tmo != 10'(TMO_TICKS)) begin
            next_r.tmo = r.tmo + 10'h001;
        end
        if (r.tmo == 10'(TMO_TICKS)) begin
            // stuck bus: back to idle, let go of sda [R8] [R9] [R10]
            next_r.st = S_IDLE;
            next_r.sda_oe = 1'b0;
        end else if (scl && r.scl_d && r.sda_d && !sda) begin
            // start always restarts the machine [R11]
            next_r.st = S_ADDR;
            next_r.bits = '0;
            next_r.sda_oe = 1'b0;
        end else if (scl && r.scl_d && !r.sda_d && sda) begin
            // stop
            next_r.st = S_IDLE;
            next_r.sda_oe = 1'b0;
        end else if (rise) begin
            // sample data and master acknowledge
            if (r.st == S_ADDR || r.st == S_WR) begin
                next_r.shift = {r.shift[6:0], sda};
                next_r.bits = r.bits + 4'h1;
            end else if (r.st == S_ACK_R) begin
                next_r.ack_ok = ~sda;
            end
        end else if (fall) begin
            unique case (r.st)
                S_IDLE: begin
                    next_r.sda_oe = 1'b0;
                end
                S_ADDR: begin
                    if (r.bits == 4'h8) begin
                        // match address, latch direction [R6] [R7]
                        if (r.shift[7:1] == SLAVE_ADDR) begin
                            next_r.sda_oe = 1'b1;
                            next_r.rw = r.shift[0];
                            next_r.st = S_ACK_A;
                        end else begin
                            next_r.st = S_IDLE;
                        end
                    end
                end
                S_ACK_A, S_ACK_R: begin
                    next_r.bits = '0;
                    if (r.st == S_ACK_R && !r.ack_ok) begin
                        next_r.st = S_IDLE;
                        next_r.sda_oe = 1'b0;
                    end else if (r.st == S_ACK_R || r.rw) begin
                        // load next byte for the master [R7]
                        next_r.shift = rdata_i;
                        next_r.sda_oe = ~rdata_i[7];
                        next_r.req.rd = 1'b1;
                        next_r.req.addr = r.ptr;
                        next_r.ptr = r.ptr + 8'h01;
                        next_r.st = S_RD;
                    end else begin
                        next_r.sda_oe = 1'b0;
                        next_r.first = 1'b1;
                        next_r.st = S_WR;
                    end
                end
                S_WR: begin
                    if (r.bits == 4'h8) begin
                        next_r.sda_oe = 1'b1;
                        next_r.st = S_ACK_W;
                        next_r.first = 1'b0;
                        if (r.first) begin
                            next_r.ptr = r.shift;
                        end else begin
                            next_r.req.wr = 1'b1;
                            next_r.req.addr = r.ptr;
                            next_r.req.wdata = r.shift;
                            next_r.ptr = r.ptr + 8'h01;
                        end
                    end
                end
                S_ACK_W: begin
                    next_r.sda_oe = 1'b0;
                    next_r.bits = '0;
                    next_r.st = S_WR;
                end
                S_RD: begin
                    if (r.bits == 4'h7) begin
                        next_r.sda_oe = 1'b0;
                        next_r.st = S_ACK_R;
                    end else begin
                        next_r.sda_oe = ~r.shift[6];
                        next_r.shift = {r.shift[6:0], 1'b0};
                        next_r.bits = r.bits + 4'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '0;
            r.scl_sy <= 2'h3;
            r.sda_sy <= 2'h3;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
            r.st <= S_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign sda_oe_o = r.sda_oe;
    assign ptr_o = r.ptr;
    assign req_o = r.req;
endmodule
`default_nettype wire

// ===== hdl/rtc_core.sv
// rtc timekeeping core: calendar, trim divider, pins, register file
`timescale 1ns/1ps
`default_nettype none
module rtc_core
    import rtc_core_pkg::*;
#(
    parameter logic [15:0] FACTORY_TRIM = FACTORY_TRIM_DEF
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // oscillator clock, already squared
    input wire logic crystal_in_first_i,
    // serial bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // open-drain outputs, enable high pulls the pin low
    output logic primary_irq_n_o,
    output logic primary_irq_n_oe_o,
    output logic secondary_irq_or_clock_pin_o,
    output logic secondary_irq_or_clock_pin_oe_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] osc_sy;        // oscillator synchroniser
        logic osc_d;
        logic [16:0] div;          // ticks within the current second
        logic [TRIM_FRAC_BITS-1:0] frac;
        logic [7:0] trim_upper;
        logic [7:0] trim_lower;
        logic [15:0] trim_act;     // code in use by the divider
        logic [7:0] clk_cfg;
        logic [7:0] int_en;
        logic [7:0] status;
        logic [CAL_FIELDS-1:0][7:0] cal;
        logic [CAL_FIELDS-1:0][7:0] shadow;
        logic pend;                // host write waiting to land
        logic [7:0] win;
        logic irq_oe;
        logic sec_oe;
    } core_t;

    core_t r;
    core_t next_r;
    reg_req_t req;
    logic [7:0] ptr;
    logic [7:0] rdata;
    logic slave_sda_oe;
    logic osc;
    logic osc_tick;

    assign osc = r.osc_sy[1];
    assign osc_tick = osc & ~r.osc_d;

    // ------------------------------------------------------------
    // bcd helpers
    // ------------------------------------------------------------
    // increment a bcd byte [R1]
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = v + 8'h01;
        end
    endfunction

    // last date of a month, bcd month and year
    function automatic logic [7:0] month_len(input logic [7:0] m,
                                             input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                       y[3:0] == 4'h8);
        unique case (m[4:0])
            5'h02: month_len = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    // advance the calendar by one second
    function automatic logic [CAL_FIELDS-1:0][7:0] cal_step(
        input logic [CAL_FIELDS-1:0][7:0] c);
        logic [CAL_FIELDS-1:0][7:0] n;
        n = c;
        n[CAL_SEC] = bcd_inc(c[CAL_SEC]);
        if (c[CAL_SEC] == 8'h59) begin
            n[CAL_SEC] = 8'h00;
            n[CAL_MIN] = bcd_inc(c[CAL_MIN]);
            if (c[CAL_MIN] == 8'h59) begin
                n[CAL_MIN] = 8'h00;
                n[CAL_HOUR] = bcd_inc(c[CAL_HOUR]);
                if (c[CAL_HOUR] == 8'h23) begin
                    // midnight rollover [R3]
                    n[CAL_HOUR] = 8'h00;
                    n[CAL_DOW] = (c[CAL_DOW] == DOW_LAST) ? CAL_ONE
                                 : bcd_inc(c[CAL_DOW]);
                    n[CAL_DATE] = bcd_inc(c[CAL_DATE]);
                    if (c[CAL_DATE] ==
                        month_len(c[CAL_MONTH], c[CAL_YEAR])) begin
                        n[CAL_DATE] = CAL_ONE;
                        n[CAL_MONTH] = bcd_inc(c[CAL_MONTH]);
                        if (c[CAL_MONTH][4:0] == 5'h12) begin
                            n[CAL_MONTH][6:0] = CAL_ONE[6:0];
                            n[CAL_YEAR] = bcd_inc(c[CAL_YEAR]);
                            if (c[CAL_YEAR] == 8'h99) begin
                                // century flag flips [R2]
                                n[CAL_YEAR] = 8'h00;
                                n[CAL_MONTH][CENTURY_BIT] =
                                    ~c[CAL_MONTH][CENTURY_BIT];
                            end
                        end
                    end
                end
            end
        end
        cal_step = n;
    endfunction

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    rtc_i2c_slave u_slave (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_oe_o(slave_sda_oe),
        .osc_tick_i(osc_tick),
        .rdata_i(rdata),
        .ptr_o(ptr),
        .req_o(req)
    );

    // ------------------------------------------------------------
    // read data mux, shows live counters in bcd
    // ------------------------------------------------------------
    always_comb begin
        rdata = 8'h00;
        case (ptr)
            REG_STATUS: rdata = r.status;
            REG_INT_EN: rdata = r.int_en;
            REG_CLK_CFG: rdata = r.clk_cfg;
            REG_TRIM_UPPER: rdata = r.trim_upper;
            REG_TRIM_LOWER: rdata = r.trim_lower;
            default: begin
                if (ptr - REG_CAL_BASE < 8'(CAL_FIELDS)) begin
                    rdata = r.cal[3'(ptr - REG_CAL_BASE)]; // [R1]
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [16:0] period;
        logic signed [16:0] sum;
        logic sec_tick;
        logic [7:0] set_bits;
        logic [7:0] clr_bits;
        logic clk_lvl;
        next_r = r;
        period = SEC_PERIOD;
        sum = '0;
        sec_tick = 1'b0;
        set_bits = 8'h00;
        clr_bits = 8'h00;
        clk_lvl = 1'b1;
        next_r.osc_sy = {r.osc_sy[0], crystal_in_first_i};
        next_r.osc_d = osc;
        // fractional divider: code is in 1/64 tick units [R16] [R21]
        sum = 17'(signed'({1'b0, r.frac})) + 17'(signed'(r.trim_act));
        period = SEC_PERIOD + 17'(sum >>> TRIM_FRAC_BITS);
        if (osc_tick) begin
            if (r.div >= period - 17'h00001) begin
                next_r.div = '0;
                next_r.frac = sum[TRIM_FRAC_BITS-1:0];
                sec_tick = 1'b1;
            end else begin
                next_r.div = r.div + 17'h00001;
            end
        end
        if (sec_tick) begin
            next_r.cal = cal_step(r.cal);
            set_bits[STAT_SEC_BIT] = 1'b1;
        end
        // shadow tracks counters while idle
        if (!r.pend) begin
            next_r.shadow = r.cal;
        end
        // settle window, then the host value lands [R5]
        if (r.pend && osc_tick) begin
            if (r.win == 8'(WIN_TICKS - 1)) begin
                next_r.pend = 1'b0;
                next_r.cal = r.shadow;
                next_r.div = '0;
            end else begin
                next_r.win = r.win + 8'h01;
            end
        end
        // register writes
        if (req.wr) begin
            if (req.addr == REG_INT_EN) begin
                next_r.int_en = req.wdata;
            end else if (req.addr == REG_CLK_CFG) begin
                next_r.clk_cfg = req.wdata;
            end else if (req.addr == REG_TRIM_UPPER) begin
                next_r.trim_upper = req.wdata;
            end else if (req.addr == REG_TRIM_LOWER) begin
                // low byte commits the full code [R19]
                next_r.trim_lower = req.wdata;
                next_r.trim_act = {r.trim_upper, req.wdata};
            end else if (req.addr - REG_CAL_BASE < 8'(CAL_FIELDS)) begin
                // stage value and restart the window [R5]
                if (!r.pend) begin
                    next_r.shadow = r.cal;
                end
                next_r.shadow[3'(req.addr - REG_CAL_BASE)] = req.wdata;
                next_r.pend = 1'b1;
                next_r.win = 8'h00;
            end
        end
        // status read clears, same-cycle set wins [R14]
        if (req.rd && req.addr == REG_STATUS) begin
            clr_bits = r.status;
        end
        next_r.status = (r.status & ~clr_bits) | set_bits;
        // primary pin low while an enabled flag is set [R12]
        next_r.irq_oe = |(next_r.status & r.int_en);
        // secondary pin function [R13] [R15]
        if (r.clk_cfg[CFG_CLK_EN_BIT]) begin
            if (r.clk_cfg[1:0] == CFG_SEL_RAW) begin
                clk_lvl = osc;
            end else begin
                clk_lvl = (r.div < SQ_HALF);
            end
        end
        next_r.sec_oe = ~clk_lvl;
    end

    // ------------------------------------------------------------
    // state register, factory trim loaded at reset [R20]
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '0;
            r.trim_upper <= FACTORY_TRIM[15:8];
            r.trim_lower <= FACTORY_TRIM[7:0];
            r.trim_act <= FACTORY_TRIM;
            r.clk_cfg <= CLK_CFG_RST;
            r.int_en <= INT_EN_RST;
            r.cal[CAL_DOW] <= CAL_ONE;
            r.cal[CAL_DATE] <= CAL_ONE;
            r.cal[CAL_MONTH] <= CAL_ONE;
            // open-drain pins only ever pull low
            sda_o <= 1'b0;
            primary_irq_n_o <= 1'b0;
            secondary_irq_or_clock_pin_o <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign sda_oe_o = slave_sda_oe;
    assign primary_irq_n_oe_o = r.irq_oe;
    assign secondary_irq_or_clock_pin_oe_o = r.sec_oe;
endmodule
`default_nettype wire

// ===== verification/rtc_core_assertions.sv
// pin-level property checker for the rtc core
`timescale 1ns/1ps
`default_nettype none
module rtc_core_assertions
    import rtc_core_pkg::*;
(
    // clock, reset, inputs
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic crystal_in_first_i,
    input wire logic scl_i,
    // core outputs
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic primary_irq_n_o,
    input wire logic primary_irq_n_oe_o,
    input wire logic secondary_irq_or_clock_pin_o,
    input wire logic secondary_irq_or_clock_pin_oe_o
);
    localparam int LOW_MIN = 819; // ticks in 25 ms
    logic [1:0] osc_q; // oscillator edge finder
    logic [11:0] low_ticks; // oscillator rises while scl is low
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // count oscillator rises over one scl low phase
    always_ff @(posedge clk_sys_i) begin
        osc_q <= {osc_q[0], crystal_in_first_i};
        if (rst_i || scl_i) begin
            low_ticks <= 12'h000;
        end else if (osc_q == 2'h1 && low_ticks != 12'hFFF) begin
            low_ticks <= low_ticks + 12'h001;
        end
    end
    AST_SDA_LEVEL: assert property (sda_o == 1'b0)
        else $error("sda drive level not low");
    AST_IRQ_LEVEL: assert property (primary_irq_n_o == 1'b0)
        else $error("irq drive level not low");
    AST_SEC_LEVEL: assert property (secondary_irq_or_clock_pin_o == 1'b0)
        else $error("secondary drive level not low");
    AST_RESET_QUIET: assert property ($past(rst_i) |-> !sda_oe_o && !primary_irq_n_oe_o)
        else $error("pin driven after reset");
    AST_SEC_RELEASED: assert property (($past(rst_i, 2) && !$past(rst_i)) |-> !secondary_irq_or_clock_pin_oe_o)
        else $error("secondary pin driven after reset");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("sda drive changed while scl high");
    AST_SDA_HOLD: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
        else $error("sda drive dropped early");
    AST_TIMEOUT: assert property (low_ticks > TMO_TICKS + 4 |-> !sda_oe_o)
        else $error("sda still driven after timeout");
    AST_NO_EARLY_TMO: assert property ($fell(sda_oe_o) |-> low_ticks < 2 || low_ticks >= LOW_MIN)
        else $error("sda released too early");
endmodule
bind rtc_core rtc_core_assertions chk_i (.*);
`default_nettype wire

// ===== verification/i2c_host_model.sv
// two-wire bus master driving the core's serial pins
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // clock and bus sense
    input wire logic clk_sys_i,
    input wire logic sda_i,
    // bus drive, enable high pulls sda low
    output logic scl_o,
    output logic sda_oe_o
);
    localparam int PH = 4; // clocks per bus phase
    // idle bus: scl high and sda released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic ph();
        repeat (PH) @(posedge clk_sys_i);
    endtask
    // one bit: data set in scl low, sampled at end of scl high
    task automatic bit_io(input logic b, output logic s);
        sda_oe_o <= !b;
        ph();
        scl_o <= 1'b1;
        ph();
        s = sda_i;
        scl_o <= 1'b0;
        ph();
    endtask
    // start or repeated start
    task automatic start();
        sda_oe_o <= 1'b0;
        ph();
        scl_o <= 1'b1;
        ph();
        sda_oe_o <= 1'b1;
        ph();
        scl_o <= 1'b0;
        ph();
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        ph();
        scl_o <= 1'b1;
        ph();
        sda_oe_o <= 1'b0;
        ph();
    endtask
    // byte msb first, then the acknowledge bit
    task automatic byte_io(input logic [7:0] d, input logic last,
                           output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(last, ack);
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the rtc timekeeping core
`timescale 1ns/1ps
`default_nettype none
module testbench import rtc_core_pkg::*;;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [15:0] gap;
        logic [7:0] exp;
    } row_t;
    localparam logic [15:0] TRIM0 = 16'hA5C3;
    localparam logic [7:0] WADDR = {SLAVE_ADDR, 1'b0};
    localparam logic [7:0] RADDR = {SLAVE_ADDR, 1'b1};
    logic clk_sys_i, rst_i, osc, scl, host_oe, dut_oe, sec_oe, r;
    logic [7:0] q, rd;
    wire logic sda = !(host_oe | dut_oe); // pulled up when released
    int miscompares, compares, edges, e0;
    row_t rows [10] = '{
        '{1'b0, 8'h1D, 8'h00, 16'h0, TRIM0[15:8]},
        '{1'b0, 8'h1E, 8'h00, 16'h0, TRIM0[7:0]},
        '{1'b1, 8'h1D, 8'h12, 16'h0, 8'h12},
        '{1'b1, 8'h1E, 8'h34, 16'h0, 8'h34},
        '{1'b1, 8'h1F, 8'h55, 16'h0, 8'h00},
        '{1'b1, 8'h08, 8'h23, 16'h0, 8'h00},
        '{1'b0, 8'h08, 8'h00, 16'h04B0, 8'h23},
        '{1'b1, 8'h0A, 8'h92, 16'h0, 8'h01},
        '{1'b0, 8'h0A, 8'h00, 16'h04B0, 8'h92},
        '{1'b1, 8'h04, 8'h07, 16'h0, 8'h07}};
    rtc_core #(.FACTORY_TRIM(TRIM0)) dut (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .crystal_in_first_i(osc), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(dut_oe), .primary_irq_n_o(),
        .primary_irq_n_oe_o(), .secondary_irq_or_clock_pin_o(),
        .secondary_irq_or_clock_pin_oe_o(sec_oe));
    i2c_host_model host (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
        .sda_oe_o(host_oe));
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = !clk_sys_i;
    end
    // free-running oscillator, 48 ns period
    initial begin
        osc = 1'b0;
        #7;
        forever #24 osc = !osc;
    end
    always @(posedge sec_oe) edges++;
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // address the core for writing and set its pointer
    task automatic point(input logic [7:0] a);
        host.start();
        host.byte_io(WADDR, 1'b1, q, r);
        chk("write ack", {7'h00, r}, 8'h00);
        host.byte_io(a, 1'b1, q, r);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        point(a);
        host.byte_io(d, 1'b1, q, r);
        host.stop();
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        point(a);
        host.start();
        host.byte_io(RADDR, 1'b1, q, r);
        chk("read ack", {7'h00, r}, 8'h00);
        host.byte_io(8'hFF, 1'b1, d, r);
        host.stop();
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        miscompares++;
        close_out();
    end
    initial begin
        rst_i = 1'b1;
        miscompares = 0;
        compares = 0;
        edges = 0;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        // reads show live counters
        for (int i = 0; i < 10; i++) begin
            if (rows[i].wr) begin
                reg_wr(rows[i].addr, rows[i].data);
            end
            repeat (rows[i].gap) @(posedge clk_sys_i);
            reg_rd(rows[i].addr, rd);
            chk("register", rd, rows[i].exp);
        end
        e0 = edges;
        repeat (192) @(posedge clk_sys_i);
        chk("raw clock edges", {7'h00, (edges - e0) inside {[19:21]}}, 8'h01);
        reg_wr(8'h04, 8'h00);
        e0 = edges;
        repeat (192) @(posedge clk_sys_i);
        chk("clock off", 8'(edges - e0), 8'h00);
        host.start();
        host.byte_io(8'hA0, 1'b1, q, r);
        chk("foreign address", {7'h00, r}, 8'h01);
        host.stop();
        // hold scl low during the acknowledge
        host.start();
        for (int i = 7; i >= 0; i--) begin
            host.bit_io(WADDR[i], r);
        end
        repeat (7500) @(posedge clk_sys_i);
        chk("ack before timeout", {7'h00, dut_oe}, 8'h01);
        repeat (4000) @(posedge clk_sys_i);
        chk("ack after timeout", {7'h00, dut_oe}, 8'h00);
        reg_rd(8'h1D, rd);
        chk("after timeout", rd, 8'h12);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        reg_rd(8'h1D, rd);
        chk("trim after reset", rd, TRIM0[15:8]);
        close_out();
    end
endmodule
`default_nettype wire
